// ==== verilog/dpram_port.sv ====
// One port of a synchronous dual-port RAM: select decode, burst counter, output timing
`timescale 1ns/10ps
`default_nettype none
module dpram_port #(
  parameter int unsigned WORDS  = dpram_pkg::WORDS,
  parameter int unsigned ADDR_W = dpram_pkg::ADDR_W,
  parameter int unsigned DATA_W = dpram_pkg::DATA_W
) (
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // Mode and selects
  input  wire logic              output_mode_select,
  input  wire logic              chip_select_low_n,
  input  wire logic              chip_select_high,
  input  wire logic              write_n,
  input  wire logic              output_enable_n,
  input  wire logic              upper_byte_enable_n,
  input  wire logic              lower_byte_enable_n,
  // Burst counter
  input  wire logic              address_strobe_load_n,
  input  wire logic              count_advance_enable_n,
  input  wire logic              counter_clear_n,
  input  wire logic [ADDR_W-1:0] address,
  // Data pins
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe,
  // Far port of the shared array
  input  wire logic              far_we,
  input  wire logic [1:0]        far_lane_en,
  input  wire logic [ADDR_W-1:0] far_addr,
  input  wire logic [DATA_W-1:0] far_wdata,
  output logic      [DATA_W-1:0] far_rdata
);
  import dpram_pkg::*;

  initial begin
    if (WORDS != (1 << ADDR_W)) $error("dpram_port: counter must span the whole array");
  end

  ram_access_if acc ();

  // Pins come from outside this clock domain: two flops each
  localparam int unsigned NSYNC = 10 + ADDR_W + DATA_W;
  logic [NSYNC-1:0] sync1_q, sync2_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_q <= '1;
      sync2_q <= '1;
    end else if (ce) begin
      sync1_q <= {output_mode_select, chip_select_low_n, chip_select_high, write_n, output_enable_n,
                  upper_byte_enable_n, lower_byte_enable_n, address_strobe_load_n,
                  count_advance_enable_n, counter_clear_n, address, data_in};
      sync2_q <= sync1_q;
    end
  end

  logic              pipe_s, cs_low_n_s, cs_high_s, write_n_s, oe_n_s, ub_n_s, lb_n_s;
  logic              ads_n_s, cnt_n_s, clr_n_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DATA_W-1:0] din_s;
  assign {pipe_s, cs_low_n_s, cs_high_s, write_n_s, oe_n_s, ub_n_s, lb_n_s,
          ads_n_s, cnt_n_s, clr_n_s, addr_s, din_s} = sync2_q;

  function automatic counter_op_t counter_op(input logic clr_n, input logic ads_n, input logic cnt_n);
    if (!clr_n)     return CNT_CLEAR;
    else if (!ads_n) return CNT_LOAD;
    else if (cnt_n) return CNT_HOLD;
    else            return CNT_ADVANCE;
  endfunction : counter_op

  counter_op_t       op;
  logic [ADDR_W-1:0] cnt_q, cnt_d, acc_addr;
  logic              sel;

  // Counter ignores the chip selects entirely
  always_comb begin
    op = counter_op(clr_n_s, ads_n_s, cnt_n_s);
    case (op)
      CNT_CLEAR:   cnt_d = ADDR_ZERO;
      CNT_LOAD:    cnt_d = addr_s;
      CNT_HOLD:    cnt_d = cnt_q;
      CNT_ADVANCE: cnt_d = cnt_q + ADDR_STEP;
      default:     cnt_d = cnt_q;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) cnt_q <= ADDR_ZERO;
    else if (ce) cnt_q <= cnt_d;
  end

  // Access uses the new counter value, so clear, load and advance cost no idle cycle
  assign acc_addr = cnt_d;
  assign sel      = !cs_low_n_s && cs_high_s;

  assign acc.we      = sel && !write_n_s;
  assign acc.rd      = sel && write_n_s;
  assign acc.lane_en = {!ub_n_s, !lb_n_s};
  assign acc.addr    = acc_addr;
  assign acc.wdata   = din_s;

  ram_array #(.WORDS(WORDS), .ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_array (
    .clk       (clk),
    .ce        (ce),
    .a         (acc.mem),
    .b_we      (far_we),
    .b_lane_en (far_lane_en),
    .b_addr    (far_addr),
    .b_wdata   (far_wdata),
    .b_rdata   (far_rdata)
  );

  // Drive state: flow stage follows last edge, pipe stage one edge later
  logic              rd1_q, rd1_d, rd2_q, rd2_d;
  logic [DATA_W-1:0] pipe_q, pipe_d;
  always_comb begin
    rd1_d  = acc.rd;
    rd2_d  = rd1_q;
    pipe_d = acc.rdata;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd1_q  <= 1'b0;
      rd2_q  <= 1'b0;
      pipe_q <= DATA_ZERO;
    end else if (ce) begin
      rd1_q  <= rd1_d;
      rd2_q  <= rd2_d;
      pipe_q <= pipe_d;
    end
  end

  // Output enable is combinational over the registered drive state
  assign data_out = pipe_s ? pipe_q : acc.rdata;
  assign data_oe  = (pipe_s ? rd2_q : rd1_q) && !oe_n_s;

  property p_clear_zero;
    @(posedge clk) disable iff (rst) (ce && !clr_n_s) |=> (cnt_q == ADDR_ZERO);
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("counter not cleared");

  property p_load;
    @(posedge clk) disable iff (rst) (ce && clr_n_s && !ads_n_s) |=> (cnt_q == $past(addr_s));
  endproperty
  a_load: assert property (p_load) else $error("counter not loaded");

  property p_hold;
    @(posedge clk) disable iff (rst) (ce && clr_n_s && ads_n_s && cnt_n_s) |=> $stable(cnt_q);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved on hold");

  property p_advance;
    @(posedge clk) disable iff (rst)
      (ce && clr_n_s && ads_n_s && !cnt_n_s) |=> (cnt_q == ADDR_W'($past(cnt_q) + 1));
  endproperty
  a_advance: assert property (p_advance) else $error("counter did not advance");

  property p_addr_pick;
    @(posedge clk) disable iff (rst) (clr_n_s && !ads_n_s) |-> (acc.addr == addr_s);
  endproperty
  a_addr_pick: assert property (p_addr_pick) else $error("access address not external");

  property p_deselect_float;
    @(posedge clk) disable iff (rst) (ce && !sel && !pipe_s) |=> !data_oe || !$stable(pipe_s);
  endproperty
  a_deselect_float: assert property (p_deselect_float) else $error("deselected port drives");

  property p_oe_async;
    @(posedge clk) disable iff (rst) oe_n_s |-> !data_oe;
  endproperty
  a_oe_async: assert property (p_oe_async) else $error("pins driven with output enable high");

  sequence s_read_flow;
    ce && acc.rd;
  endsequence
  sequence s_hold_ce;
    ce [*2];
  endsequence
  property p_pipe_later;
    @(posedge clk) disable iff (rst) (s_read_flow ##0 s_hold_ce) |=> rd2_q;
  endproperty
  a_pipe_later: assert property (p_pipe_later) else $error("pipe stage missed read");
endmodule : dpram_port
`default_nettype wire

// ==== include/dpram_pkg.sv ====
// Package: sizes, reset values and timing constants for one synchronous dual-port RAM port
package dpram_pkg;
  localparam int unsigned WORDS          = 16384;
  localparam int unsigned ADDR_W         = 14;
  localparam int unsigned DATA_W         = 16;
  localparam int unsigned LANE_W         = 8;
  localparam logic [13:0] ADDR_ZERO      = 14'h0000;
  localparam logic [13:0] ADDR_STEP      = 14'h0001;
  localparam logic [15:0] DATA_ZERO      = 16'h0000;
  localparam int unsigned CLK_PERIOD_NS  = 40;
  // Port-to-port figures in ns, as printed for the fastest grade
  localparam int unsigned CLOCK_TO_CLOCK_SETUP_NS = 9;
  localparam int unsigned WRITE_TO_READ_DELAY_NS  = 30;
  localparam int unsigned FLOW_CLOCK_TO_DATA_NS   = 15;
  // Setup and write-to-read times round down to cycles, never below one cycle
  localparam int unsigned CLOCK_TO_CLOCK_SETUP_CYC =
    (CLOCK_TO_CLOCK_SETUP_NS / CLK_PERIOD_NS) < 1 ? 1 : CLOCK_TO_CLOCK_SETUP_NS / CLK_PERIOD_NS;
  localparam int unsigned WRITE_TO_READ_DELAY_CYC =
    (WRITE_TO_READ_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 : WRITE_TO_READ_DELAY_NS / CLK_PERIOD_NS;
  typedef enum logic [1:0] {CNT_CLEAR, CNT_LOAD, CNT_HOLD, CNT_ADVANCE} counter_op_t;
endpackage : dpram_pkg

// ==== include/ram_access_if.sv ====
// Interface: access path between the port control and the shared array
`timescale 1ns/10ps
`default_nettype none
interface ram_access_if;
  logic                         we;
  logic [1:0]                   lane_en;
  logic [dpram_pkg::ADDR_W-1:0] addr;
  logic [dpram_pkg::DATA_W-1:0] wdata;
  logic [dpram_pkg::DATA_W-1:0] rdata;
  logic                         rd;
  modport ctrl (output we, output lane_en, output addr, output wdata, output rd, input rdata);
  modport mem  (input we, input lane_en, input addr, input wdata, input rd, output rdata);
endinterface : ram_access_if
`default_nettype wire

// ==== verilog/ram_array.sv ====
// Array of words with two clocked ports sharing it; port a is this port, port b the far port
`timescale 1ns/10ps
`default_nettype none
module ram_array #(
  parameter int unsigned WORDS  = dpram_pkg::WORDS,
  parameter int unsigned ADDR_W = dpram_pkg::ADDR_W,
  parameter int unsigned DATA_W = dpram_pkg::DATA_W
) (
  // Clocking
  input  wire logic              clk,
  input  wire logic              ce,
  // This port
  ram_access_if.mem              a,
  // Far port
  input  wire logic              b_we,
  input  wire logic [1:0]        b_lane_en,
  input  wire logic [ADDR_W-1:0] b_addr,
  input  wire logic [DATA_W-1:0] b_wdata,
  output logic      [DATA_W-1:0] b_rdata
);
  import dpram_pkg::*;
  localparam int unsigned HALF = DATA_W / 2;

  initial begin
    if (WORDS > (1 << ADDR_W) || DATA_W % 2 != 0) $error("ram_array: bad size");
  end

  logic [DATA_W-1:0] mem [WORDS];
  logic [DATA_W-1:0] a_rdata_q;
  logic [DATA_W-1:0] b_rdata_q;

  // Write-first per lane, so a read that meets a write from the other port on the same word sees new data
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w, input logic [DATA_W-1:0] new_w,
                                              input logic [1:0] en);
    logic [DATA_W-1:0] r;
    r = old_w;
    if (en[0]) r[HALF-1:0] = new_w[HALF-1:0];
    if (en[1]) r[DATA_W-1:HALF] = new_w[DATA_W-1:HALF];
    return r;
  endfunction : merge

  always_ff @(posedge clk) begin
    if (ce) begin
      if (a.we) mem[a.addr] <= merge(mem[a.addr], a.wdata, a.lane_en);
      if (b_we && !(a.we && a.addr == b_addr)) mem[b_addr] <= merge(mem[b_addr], b_wdata, b_lane_en);
      a_rdata_q <= (b_we && b_addr == a.addr) ? merge(mem[a.addr], b_wdata, b_lane_en) : mem[a.addr];
      b_rdata_q <= (a.we && a.addr == b_addr) ? merge(mem[b_addr], a.wdata, a.lane_en) : mem[b_addr];
    end
  end

  assign a.rdata = a_rdata_q;
  assign b_rdata = b_rdata_q;
endmodule : ram_array
`default_nettype wire

// ==== bench/host_model.sv ====
// Host controller model: drives the control, address and write data pins of one port
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // Clock
  input  wire logic        clk,
  // Port pins: chip select low, high, write, oe, upper, lower, strobe, count, clear
  output logic [8:0]       ctl,
  output logic [13:0]      addr,
  output logic [15:0]      wdat
);
  initial begin
    ctl  = 9'h17f;
    addr = 14'h0000;
    wdat = 16'h0000;
  end

  // Pins change just after an edge and stand for one whole cycle
  task automatic op(input logic [8:0] c, input logic [13:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    ctl  = c;
    addr = a;
    wdat = d;
  endtask : op
endmodule : host_model
`default_nettype wire

// ==== bench/tb.sv ====
// Testbench: the host model drives one port and a scoreboard checks what the pins return
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dpram_pkg::*;
  logic        clk       = 1'b0;
  logic        rst       = 1'b1;
  logic        mode      = 1'b0;
  logic        far_we    = 1'b0;
  logic [13:0] far_addr  = 14'h0000;
  logic [15:0] far_wdata = 16'h0000;
  logic [8:0]  ctl;
  logic [13:0] addr;
  logic [15:0] wdat;
  logic [15:0] data_out;
  logic [15:0] far_rdata;
  logic [15:0] r;
  logic        data_oe;
  logic [15:0] mem [0:16383];
  logic [15:0] notes [$];
  logic [16:0] lag [0:1] = '{17'h00000, 17'h00000};
  int          bad_count   = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  int          seed        = 56984;

  always #20 clk = ~clk;

  host_model i_host_model (.clk(clk), .ctl(ctl), .addr(addr), .wdat(wdat));

  dpram_port i_dpram_port (.clk(clk), .rst(rst), .ce(1'b1), .output_mode_select(mode),
    .chip_select_low_n(ctl[8]), .chip_select_high(ctl[7]), .write_n(ctl[6]), .output_enable_n(ctl[5]),
    .upper_byte_enable_n(ctl[4]), .lower_byte_enable_n(ctl[3]), .address_strobe_load_n(ctl[2]),
    .count_advance_enable_n(ctl[1]), .counter_clear_n(ctl[0]), .address(addr), .data_in(wdat),
    .data_out(data_out), .data_oe(data_oe), .far_we(far_we), .far_lane_en(2'b11), .far_addr(far_addr),
    .far_wdata(far_wdata), .far_rdata(far_rdata));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // Output enable takes two flops, read data three (four when pipelined), so the
  // enable of a later op gates the pins while an earlier read is on them
  task automatic issue(input logic [8:0] c, input logic [13:0] a, input logic [15:0] d, input logic [16:0] e);
    logic [16:0] due;
    due = mode ? lag[1] : lag[0];
    if (due[16] && !c[5]) notes.push_back(due[15:0]);
    lag[1] = lag[0];
    lag[0] = e;
    i_host_model.op(c, a, d);
  endtask : issue

  // A deselected write leaves the word alone; a disabled upper lane keeps its old byte
  task automatic wr(input logic [8:0] c, input logic [13:0] a);
    r = 16'($random(seed));
    if (!c[8] && c[7]) mem[a] = {c[4] ? mem[a][15:8] : r[15:8], r[7:0]};
    issue(c, a, r, 17'h00000);
  endtask : wr

  // Only a selected read drives the pins, and only while the output is enabled
  task automatic rd(input logic [8:0] c, input logic [13:0] a, input logic [13:0] word);
    issue(c, a, ~r, {c[7] && !c[8] && c[6], mem[word]});
  endtask : rd

  // Deselected with the output enabled, so the last read before it is still seen
  task automatic idle(input int n);
    repeat (n) issue(9'h15f, ~addr, ~wdat, 17'h00000);
  endtask : idle

  always @(posedge clk) begin
    #2;
    if (data_oe === 1'b1) begin
      if (notes.size() == 0)
        check("data_oe", 16'(data_oe), 16'h0000);
      else
        check("data_out", data_out, notes.pop_front());
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      stop_test();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk);
      #1 mode = m[0];
      wr(9'h0a3, 14'h3fff);
      for (int i = 0; i < 7; i++)
        wr(9'h0a3, 14'(i));
      wr(9'h0b3, 14'h0002);
      wr(9'h1a3, 14'h0003);
      wr(9'h0a3, 14'h0003);
      rd(9'h0c3, 14'h0003, 14'h0003);
      rd(9'h0c5, 14'h1111, 14'h0004);
      rd(9'h0c7, 14'h2222, 14'h0004);
      rd(9'h0c2, 14'h0005, 14'h0000);
      rd(9'h0c3, 14'h3fff, 14'h3fff);
      rd(9'h0c5, 14'h0006, 14'h0000);
      rd(9'h045, 14'h0006, 14'h0001);
      rd(9'h0c5, 14'h0006, 14'h0002);
      rd(9'h0e3, 14'h0005, 14'h0005);
      rd(9'h0c3, 14'h0002, 14'h0002);
      idle(6);
      $display("test mode %0d done", m);
    end
    // Far port writes a word that this port then reads; far port reads a word this port wrote
    mode = 1'b0;
    idle(3);
    @(posedge clk);
    #1;
    far_we    = 1'b1;
    far_addr  = 14'h0009;
    far_wdata = 16'($random(seed));
    mem[9]    = far_wdata;
    @(posedge clk);
    #1;
    far_we    = 1'b0;
    far_addr  = 14'h0001;
    rd(9'h0c3, 14'h0009, 14'h0009);
    check("far_rdata", far_rdata, mem[1]);
    idle(6);
    $display("test far port done");
    check("pending", 16'(notes.size()), 16'h0000);
    stop_test();
  end
endmodule : tb
`default_nettype wire
